// ==== include/phy_vendor_regs_defs.vh ====
// Register offsets, field positions and reset values of the vendor control bank
`ifndef PHY_VENDOR_REGS_DEFS_VH
`define PHY_VENDOR_REGS_DEFS_VH
`define ADDR_DIGITAL_POWER_OPTION  5'h10
`define ADDR_ANALOG_FE_CONTROL_ONE 5'h11
`define ADDR_ANALOG_FE_CONTROL_FOUR 5'h13
`define ADDR_SYMBOL_ERROR_COUNT    5'h15
`define BIT_PLL_OFF_IN_POWER_DOWN  4
`define BIT_SLOW_OSC_ENABLE        5
`define BIT_REDUCED_AMPLITUDE      4
`define RST_DIGITAL_POWER_OPTION   16'h0000
`define RST_ANALOG_FE_CONTROL_ONE  16'h0000
`define RST_ANALOG_FE_CONTROL_FOUR 16'h0000
`define RST_SYMBOL_ERROR_COUNT     16'h0000
`endif

// ==== design/symbol_error_counter.v ====
// Saturating read-clear counter of received symbol-error frames
`timescale 1ns/100ps
`default_nettype none
`include "phy_vendor_regs_defs.vh"
module symbol_error_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             sys_rst_in,
  // Events and read clear
  input  wire             frame_error_in,
  input  wire             read_clear_in,
  // Count
  output wire [WIDTH-1:0] count_out
);
  reg  [WIDTH-1:0] count_r;
  reg  [WIDTH-1:0] count_nxt;
  wire             at_max;

  assign at_max    = &count_r;
  assign count_out = count_r;

  // An error arriving with the read-clear is kept as a count of one
  always @*
  begin
    count_nxt = count_r;
    if (read_clear_in)
      count_nxt = frame_error_in ? {{(WIDTH-1){1'b0}}, 1'b1}
                                 : {WIDTH{1'b0}};            // RQ6
    else if (frame_error_in && !at_max)
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};       // RQ6
  end

  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      count_r <= `RST_SYMBOL_ERROR_COUNT;
    else
      count_r <= count_nxt;
  end
endmodule // symbol_error_counter
`default_nettype wire

// ==== design/phy_vendor_control_regs.v ====
// Vendor control register bank: power options, amplitude, error count
`timescale 1ns/100ps
`default_nettype none
`include "phy_vendor_regs_defs.vh"
// Summary of operation
// RQ1: PLL-off bit set turns PLL off during energy-detect power-down.
// RQ2: Slow-oscillator bit set drops crystal input, uses on-chip oscillator.
// RQ3: Slow-oscillator mode also forces analog front end power-down.
// RQ4: Reduced-amplitude bit picks 1.75V 10BASE-Te, else 2.5V 10BASE-T.
// RQ5: Host writes companion MMD bit opposite to reduced-amplitude bit.
// RQ6: Sixteen-bit read-clear counter of symbol-error frames, resets zero.
module phy_vendor_control_regs #(
  parameter DATA_W = 16,
  parameter ADDR_W = 5
) (
  // Clock and reset
  input  wire              clock_in,
  input  wire              sys_rst_in,
  // Management register access
  input  wire [ADDR_W-1:0] reg_addr_in,
  input  wire              reg_write_in,
  input  wire              reg_read_in,
  input  wire [DATA_W-1:0] reg_wdata_in,
  output reg  [DATA_W-1:0] reg_rdata_out,
  output reg               reg_rvalid_out,
  // Device status inputs
  input  wire              energy_detect_power_down_in,
  input  wire              sw_analog_power_down_in,
  input  wire              receive_symbol_error_in,
  // Controls to the device
  output reg               pll_enable_out,
  output reg               crystal_input_pin_select_out,
  output reg               slow_oscillator_select_out,
  output reg               analog_front_end_power_down_out,
  output reg               reduced_amplitude_select_out
);
  // Register storage
  reg  [DATA_W-1:0] digital_power_option_control_r;
  reg  [DATA_W-1:0] analog_frontend_control_one_r;
  reg  [DATA_W-1:0] analog_frontend_control_four_r;
  // Read path
  reg  [DATA_W-1:0] rdata_nxt;
  reg  [DATA_W-1:0] rdata_hold_nxt;
  reg               rvalid_nxt;
  // Next values of the device controls
  reg               pll_enable_nxt;
  reg               crystal_select_nxt;
  reg               slow_osc_nxt;
  reg               analog_pd_nxt;
  reg               reduced_amp_nxt;
  // Error counting
  reg               err_d_r;
  wire [DATA_W-1:0] err_count;
  wire              frame_error_pulse;
  wire              count_read;
  // Write decode and selected option bits
  wire              wr_power_option;
  wire              wr_fe_one;
  wire              wr_fe_four;
  wire              pll_off_sel;
  wire              slow_osc_sel;
  wire              reduced_amp_sel;

  // Error flag arrives from the receive logic on this clock
  assign frame_error_pulse = receive_symbol_error_in & ~err_d_r;
  assign count_read        = reg_read_in &&
                             (reg_addr_in == `ADDR_SYMBOL_ERROR_COUNT);

  // Writes to the counter or unmapped offsets are dropped
  assign wr_power_option = reg_write_in &&
                           (reg_addr_in == `ADDR_DIGITAL_POWER_OPTION);
  assign wr_fe_one       = reg_write_in &&
                           (reg_addr_in == `ADDR_ANALOG_FE_CONTROL_ONE);
  assign wr_fe_four      = reg_write_in &&
                           (reg_addr_in == `ADDR_ANALOG_FE_CONTROL_FOUR);

  // Option bits picked out of the stored words
  assign pll_off_sel     =
    digital_power_option_control_r[`BIT_PLL_OFF_IN_POWER_DOWN];
  assign slow_osc_sel    =
    analog_frontend_control_one_r[`BIT_SLOW_OSC_ENABLE];
  assign reduced_amp_sel =
    analog_frontend_control_four_r[`BIT_REDUCED_AMPLITUDE];

  symbol_error_counter #(
    .WIDTH          (DATA_W)
  ) u_err_count (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .frame_error_in (frame_error_pulse),
    .read_clear_in  (count_read),                            // RQ6
    .count_out      (err_count)
  );

  // Previous level of the error flag, for edge detection
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      err_d_r <= 1'b0;
    else
      err_d_r <= receive_symbol_error_in;
  end

  // Reserved bits keep whatever was written to them
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      digital_power_option_control_r <= `RST_DIGITAL_POWER_OPTION;
    else if (wr_power_option)
      digital_power_option_control_r <= reg_wdata_in;
  end

  // Holds the slow oscillator enable
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      analog_frontend_control_one_r <= `RST_ANALOG_FE_CONTROL_ONE;
    else if (wr_fe_one)
      analog_frontend_control_one_r <= reg_wdata_in;
  end

  // Holds the transmit level select
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      analog_frontend_control_four_r <= `RST_ANALOG_FE_CONTROL_FOUR;
    else if (wr_fe_four)
      analog_frontend_control_four_r <= reg_wdata_in;
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    case (reg_addr_in)
      `ADDR_DIGITAL_POWER_OPTION:   rdata_nxt = digital_power_option_control_r;
      `ADDR_ANALOG_FE_CONTROL_ONE:  rdata_nxt = analog_frontend_control_one_r;
      `ADDR_ANALOG_FE_CONTROL_FOUR: rdata_nxt = analog_frontend_control_four_r;
      `ADDR_SYMBOL_ERROR_COUNT:     rdata_nxt = err_count;   // RQ6
      default:                      rdata_nxt = {DATA_W{1'b0}};
    endcase
  end

  // Read answer; data holds until the next read
  always @*
  begin
    rvalid_nxt     = reg_read_in;
    rdata_hold_nxt = reg_rdata_out;
    if (reg_read_in)
      rdata_hold_nxt = rdata_nxt;
  end

  // Count is captured on the same edge that clears it
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out  <= {DATA_W{1'b0}};
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out  <= rdata_hold_nxt;
      reg_rvalid_out <= rvalid_nxt;
    end
  end

  // Next values of the device controls
  always @*
  begin
    pll_enable_nxt = 1'b1;
    if (pll_off_sel && energy_detect_power_down_in)
      pll_enable_nxt = 1'b0;                                 // RQ1
    crystal_select_nxt = ~slow_osc_sel;                      // RQ2
    slow_osc_nxt       = slow_osc_sel;                       // RQ2
    analog_pd_nxt      = slow_osc_sel | sw_analog_power_down_in; // RQ3
    reduced_amp_nxt    = reduced_amp_sel;                    // RQ4
  end

  // PLL runs unless both the option and power-down are active
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      pll_enable_out <= 1'b1;
    else
      pll_enable_out <= pll_enable_nxt;                      // RQ1
  end

  // Clock source selects are never high together
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      crystal_input_pin_select_out <= 1'b1;
      slow_oscillator_select_out   <= 1'b0;
    end
    else
    begin
      crystal_input_pin_select_out <= crystal_select_nxt;    // RQ2
      slow_oscillator_select_out   <= slow_osc_nxt;          // RQ2
    end
  end

  // Slow oscillator mode powers the analog side down by itself
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      analog_front_end_power_down_out <= 1'b0;
    else
      analog_front_end_power_down_out <= analog_pd_nxt;      // RQ3
  end

  // Transmit level: 1 reduced amplitude, 0 standard
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      reduced_amplitude_select_out <= 1'b0;
    else
      reduced_amplitude_select_out <= reduced_amp_nxt;       // RQ4
  end
endmodule // phy_vendor_control_regs
`default_nettype wire

// ==== dv/vc_sva.sv ====
// Assertions on control outputs and read answers
`timescale 1ns/100ps
`default_nettype none
`include "phy_vendor_regs_defs.vh"
module vc_sva (
  // Clock, reset and register access
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_rvalid_out,
  // Power and clock controls
  input wire logic        energy_detect_power_down_in,
  input wire logic        sw_analog_power_down_in,
  input wire logic        pll_enable_out,
  input wire logic        crystal_input_pin_select_out,
  input wire logic        slow_oscillator_select_out,
  input wire logic        analog_front_end_power_down_out,
  input wire logic        reduced_amplitude_select_out
);
  logic pll_off_mirror;
  logic amp_mirror;
  // Shadow copies of the written PLL-off and reduced-amplitude bits
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      pll_off_mirror <= 1'b0;
      amp_mirror     <= 1'b0;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == `ADDR_DIGITAL_POWER_OPTION)
        pll_off_mirror <= reg_wdata_in[`BIT_PLL_OFF_IN_POWER_DOWN];
      if (reg_addr_in == `ADDR_ANALOG_FE_CONTROL_FOUR)
        amp_mirror <= reg_wdata_in[`BIT_REDUCED_AMPLITUDE];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence rd_req; reg_read_in; endsequence
  sequence rd_ans; reg_rvalid_out; endsequence
  a_pll_stop_cause: assert property (
    pll_enable_out ==
      !($past(pll_off_mirror) && $past(energy_detect_power_down_in)))
    else $error("pll state differs from option and power down");
  a_osc_exclusive: assert property (
    slow_oscillator_select_out != crystal_input_pin_select_out)
    else $error("clock source select clash");
  a_osc_analog_down: assert property (
    analog_front_end_power_down_out ==
      (slow_oscillator_select_out | $past(sw_analog_power_down_in)))
    else $error("analog power down differs from its causes");
  a_amp_follow: assert property (
    reduced_amplitude_select_out == $past(amp_mirror))
    else $error("transmit level differs from written bit");
  a_read_answer: assert property (rd_req |=> rd_ans)
    else $error("read not answered");
  a_answer_cause: assert property (rd_ans |-> $past(reg_read_in))
    else $error("answer without read");
endmodule // vc_sva
bind phy_vendor_control_regs vc_sva u_sva (
  .clock_in                        (clock_in),
  .sys_rst_in                      (sys_rst_in),
  .reg_addr_in                     (reg_addr_in),
  .reg_write_in                    (reg_write_in),
  .reg_read_in                     (reg_read_in),
  .reg_wdata_in                    (reg_wdata_in),
  .reg_rvalid_out                  (reg_rvalid_out),
  .energy_detect_power_down_in     (energy_detect_power_down_in),
  .sw_analog_power_down_in         (sw_analog_power_down_in),
  .pll_enable_out                  (pll_enable_out),
  .crystal_input_pin_select_out    (crystal_input_pin_select_out),
  .slow_oscillator_select_out      (slow_oscillator_select_out),
  .analog_front_end_power_down_out (analog_front_end_power_down_out),
  .reduced_amplitude_select_out    (reduced_amplitude_select_out)
);
`default_nettype wire

// ==== dv/mgmt_host.sv ====
// Management host model issuing register strobes
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
  input  wire logic        clock_in,
  input  wire logic        reg_rvalid_out,
  input  wire logic [15:0] reg_rdata_out,
  output var  logic [4:0]  reg_addr_in,
  output var  logic        reg_write_in,
  output var  logic        reg_read_in,
  output var  logic [15:0] reg_wdata_in
);
  initial {reg_addr_in, reg_write_in, reg_read_in, reg_wdata_in} = '0;
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= w;
    reg_read_in  <= !w;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
    reg_read_in  <= 1'b0;
    // Idle bus shows inverted address and data
    reg_addr_in  <= ~a;
    reg_wdata_in <= ~d;
    @(negedge clock_in);
    q = (reg_rvalid_out === !w) ? reg_rdata_out : 16'hXXXX;
  endtask
endmodule // mgmt_host
`default_nettype wire

// ==== dv/test_phy_vendor_control_regs.sv ====
// Bench comparing the register bank with a behavioural model
`timescale 1ns/100ps
`default_nettype none
module test_phy_vendor_control_regs;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, pdn = 1'b0, err = 1'b0;
  logic swpd = 1'b0, comp = 1'b1;
  logic rv, wr_s, rd_s, pll, xtal, slow, apd, amp;
  logic [4:0] addr;
  logic [15:0] wd, rdat, q;
  logic [15:0] m [0:31] = '{default: 16'h0000};
  integer n_mismatch = 0, checks = 0, cyc = 0, cnt = 0, i, k;
  integer seed = 32'hA82BADEE;
  always #4 clock_in = ~clock_in;
  phy_vendor_control_regs uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .energy_detect_power_down_in(pdn), .sw_analog_power_down_in(swpd),
    .receive_symbol_error_in(err), .pll_enable_out(pll),
    .crystal_input_pin_select_out(xtal), .slow_oscillator_select_out(slow),
    .analog_front_end_power_down_out(apd),
    .reduced_amplitude_select_out(amp));
  mgmt_host host (.clock_in(clock_in), .reg_rvalid_out(rv),
    .reg_rdata_out(rdat), .reg_addr_in(addr), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_wdata_in(wd));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q);
    if (a inside {5'h10, 5'h11, 5'h13}) m[a] = d;
    if (a == 5'h13) comp = !d[4];
  endtask
  task rdc(input logic [4:0] a);
    host.acc(1'b0, a, 16'h0000, q);
    chk("rdata", (a == 5'h15) ? cnt[15:0] : m[a], q);
    if (a == 5'h15) cnt = 0;
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    for (i = 16; i < 24; i++) rdc(i[4:0]);
    wr(5'h15, 16'hFFFF);
    for (k = 0; k < 2; k++)
    begin
      wr(5'h10, (16'($random(seed)) & 16'hFFEF) | 16'(k << 4));
      wr(5'h11, (16'($random(seed)) & 16'hFFDF) | 16'(k << 5));
      wr(5'h13, (16'($random(seed)) & 16'hFFEF) | 16'(k << 4));
      @(posedge clock_in);
      pdn  <= 1'b1;
      swpd <= 1'($random(seed));
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      chk("pll", 16'(!k[0]), 16'(pll));
      chk("slow", 16'(k[0]), 16'(slow));
      chk("xtal", 16'(!k[0]), 16'(xtal));
      chk("analog_pd", 16'(k[0] | swpd), 16'(apd));
      chk("amp", 16'(k[0]), 16'(amp));
      chk("companion", 16'(!k[0]), 16'(comp));
      @(posedge clock_in);
      pdn <= 1'b0;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      chk("pll_idle", 16'h0001, 16'(pll));
      for (i = 16; i < 20; i++) rdc(i[4:0]);
    end
    k = {$random(seed)} % 9 + 1;
    repeat (k)
    begin
      @(posedge clock_in);
      err <= 1'b1;
      @(posedge clock_in);
      err <= 1'b0;
      cnt++;
    end
    rdc(5'h15);
    rdc(5'h15);
    results;
  end
endmodule // test_phy_vendor_control_regs
`default_nettype wire
